/* File: src/pdb_pkg.sv */
package pdb_pkg;

    // Clock and DRAM strobe timing, times in ns and derived cycle counts
    localparam int CLK_PERIOD_NS = 25;
    localparam int ROW_HOLD_NS   = 40;
    localparam int ROW_HOLD_CYC  = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COL_SETUP_NS  = 20;
    localparam int COL_SETUP_CYC = (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 4;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CLEAR  = 8'h08;

    // Control field positions and values after reset
    localparam int         CTRL_RANGE_LSB = 0;
    localparam int         CTRL_MODE_LSB  = 4;
    localparam logic [2:0] CTRL_RANGE_RST = 3'h0;
    localparam logic [2:0] CTRL_MODE_RST  = 3'h0;
    localparam logic [2:0] MODE_AUTO      = 3'h0;

    // Status field positions
    localparam int STAT_FLAG_BIT  = 0;
    localparam int STAT_LINE_BIT  = 1;
    localparam int STAT_RCNT_LSB  = 8;

    localparam int         RCNT_W      = 9;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PDB_IDLE = 3'h0,
        PDB_ROW  = 3'h1,
        PDB_COL  = 3'h3,
        PDB_HOLD = 3'h2,
        PDB_REFR = 3'h6
    } pdb_fsm_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } pdb_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pdb_axi_rsp_t;

    // Memory bus pins seen by the board, sampled through two flops
    typedef struct packed {
        logic        address_valid_n;
        logic [23:0] addr;
        logic [3:0]  byte_lane_enables_n;
        logic        read_not_write;
        logic        data_strobe_n;
        logic        refresh_cycle_n;
        logic        buffer_drive_enable_n;
        logic        parity_flag_clear_n;
        logic [31:0] data;
    } pdb_bus_in_t;

    localparam pdb_bus_in_t BUS_IDLE = '1;

    typedef struct packed {
        logic [8:0] dram_mux_addr;
        logic [1:0] bank_row_strobes_n;
        logic [3:0] byte_column_strobes_n;
        logic       dram_write_n;
    } pdb_dram_out_t;

    // Odd parity bit of one byte
    function automatic logic pdb_odd_par(input logic [7:0] b);
        return ~^b;
    endfunction : pdb_odd_par

endpackage : pdb_pkg

/* File: src/pdb_board.sv */
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Decode A21-A23 against jumper, drive board_select_n
// - Two banks, A2-A20 double-word address
// - Mux row A11-A19 then column A2-A10
// - Row strobe then column strobe after strobe
// - A20 picks the bank row strobe
// - Column strobe per lane ORed with enable
// - DRAM write strobe copies read_not_write
// - Access only when selected, auto mode, no refresh
// - Refresh ignores address, uses refresh counter
// - Generate byte parity on write, check on read
// - Capture parity result at strobe trailing edge
// - Captured error drives open-drain fault line
// - Flag cleared by reset or clear access
// - Transceiver enables only for own reads/writes
// - No wait states at 10 MHz processor
module pdb_board (
    input  wire logic                   clk,
    input  wire logic                   reset,
    input  wire pdb_pkg::pdb_axi_req_t  axi_req,
    output      pdb_pkg::pdb_axi_rsp_t  axi_rsp,
    input  wire pdb_pkg::pdb_bus_in_t   bus_in,
    input  wire logic [35:0]            mem_rd_data,
    output      logic [35:0]            mem_wr_data,
    output      logic [31:0]            bus_rd_data,
    output      logic                   bus_drive_oe_n,
    output      logic                   mem_drive_oe_n,
    output      logic                   board_select_n,
    output      pdb_pkg::pdb_dram_out_t dram_out,
    input  wire logic                   parity_fault_in,
    output      logic                   parity_fault_out,
    output      logic                   parity_fault_oe_n
);

    typedef struct packed {
        pdb_pkg::pdb_bus_in_t  bus_s1;
        pdb_pkg::pdb_bus_in_t  bus_s2;
        logic [35:0]           mem_s1;
        logic [35:0]           mem_s2;
        logic                  pf_s1;
        logic                  pf_s2;
        logic                  stb_prev;
        pdb_pkg::pdb_fsm_t     fsm;
        logic [pdb_pkg::CNT_W-1:0]  cnt;
        logic [20:2]           acc_addr;
        logic                  acc_read;
        logic [3:0]            acc_ble_n;
        logic [pdb_pkg::RCNT_W-1:0] rcnt;
        logic                  cas_n;
        logic                  check_err;
        logic                  flag;
        logic [2:0]            ctrl_range;
        logic [2:0]            ctrl_mode;
        pdb_pkg::pdb_dram_out_t dram;
        logic                  board_sel_n;
        logic                  bus_oe_n;
        logic                  mem_oe_n;
        logic                  pf_oe_n;
        logic [35:0]           mem_wr;
        logic [31:0]           bus_rd;
        logic                  aw_full;
        logic [7:0]            aw_addr;
        logic                  w_full;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        pdb_pkg::pdb_axi_rsp_t rsp;
    } pdb_state_t;

    pdb_state_t q;
    pdb_state_t d;

    // Decoded views of the synchronised bus, shared with the checks below
    logic stb_fall;
    logic stb_rise;
    logic sel_now;
    logic refresh_now;
    logic auto_mode;
    logic rd_err;
    logic sw_clear;

    assign stb_fall    = q.stb_prev && !q.bus_s2.data_strobe_n;
    assign stb_rise    = !q.stb_prev && q.bus_s2.data_strobe_n;
    assign refresh_now = !q.bus_s2.refresh_cycle_n;
    assign auto_mode   = q.ctrl_mode == pdb_pkg::MODE_AUTO;
    // Dummy cycles keep address_valid_n high, so no range decodes then
    assign sel_now     = !q.bus_s2.address_valid_n
                         && q.bus_s2.addr[23:21] == q.ctrl_range;

    // Stored parity against the data read back, one bit per lane
    always_comb begin
        rd_err = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd_err = rd_err | (q.mem_s2[32+i]
                     != pdb_pkg::pdb_odd_par(q.mem_s2[8*i +: 8]));
        end
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        sw_clear = 1'b0;
        d.bus_s1  = bus_in;
        d.bus_s2  = q.bus_s1;
        d.mem_s1  = mem_rd_data;
        d.mem_s2  = q.mem_s1;
        d.pf_s1   = parity_fault_in;
        d.pf_s2   = q.pf_s1;
        d.stb_prev = q.bus_s2.data_strobe_n;
        d.check_err = rd_err;

        // Strobe sequencer; strobes return only when the master ends the strobe
        unique case (q.fsm)
            pdb_pkg::PDB_IDLE: begin
                if (stb_fall && refresh_now) begin
                    d.fsm = pdb_pkg::PDB_REFR;
                    d.dram.dram_mux_addr = q.rcnt;
                    d.dram.bank_row_strobes_n = 2'h0;
                end else if (stb_fall && sel_now && auto_mode) begin
                    d.fsm = pdb_pkg::PDB_ROW;
                    d.acc_addr  = q.bus_s2.addr[20:2];
                    d.acc_read  = q.bus_s2.read_not_write;
                    d.acc_ble_n = q.bus_s2.byte_lane_enables_n;
                    d.dram.dram_mux_addr = q.bus_s2.addr[19:11];
                    d.dram.bank_row_strobes_n = q.bus_s2.addr[20] ? 2'h1 : 2'h2;
                    d.cnt = pdb_pkg::CNT_W'(pdb_pkg::ROW_HOLD_CYC - 1);
                end
            end
            pdb_pkg::PDB_ROW: begin
                if (stb_rise) begin
                    d.fsm = pdb_pkg::PDB_IDLE;
                    d.dram.bank_row_strobes_n = 2'h3;
                end else if (q.cnt == '0) begin
                    d.fsm = pdb_pkg::PDB_COL;
                    d.dram.dram_mux_addr = q.acc_addr[10:2];
                    d.cnt = pdb_pkg::CNT_W'(pdb_pkg::COL_SETUP_CYC - 1);
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            pdb_pkg::PDB_COL: begin
                if (stb_rise) begin
                    d.fsm = pdb_pkg::PDB_IDLE;
                    d.dram.bank_row_strobes_n = 2'h3;
                end else if (q.cnt == '0) begin
                    d.fsm = pdb_pkg::PDB_HOLD;
                    d.cas_n = 1'b0;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            pdb_pkg::PDB_HOLD: begin
                if (stb_rise) begin
                    d.fsm = pdb_pkg::PDB_IDLE;
                    d.cas_n = 1'b1;
                    d.dram.bank_row_strobes_n = 2'h3;
                end
            end
            pdb_pkg::PDB_REFR: begin
                if (stb_rise) begin
                    d.fsm = pdb_pkg::PDB_IDLE;
                    d.dram.bank_row_strobes_n = 2'h3;
                    d.rcnt = q.rcnt + 1'b1;
                end
            end
            default: begin
                d.fsm = pdb_pkg::PDB_IDLE;
                d.cas_n = 1'b1;
                d.dram.bank_row_strobes_n = 2'h3;
            end
        endcase

        // Lane gating keeps disabled bytes untouched on partial writes
        d.dram.byte_column_strobes_n = {4{d.cas_n}} | d.acc_ble_n;
        d.dram.dram_write_n = q.bus_s2.read_not_write;

        // Write data carries its own byte parity into the array
        d.mem_wr[31:0] = q.bus_s2.data;
        for (int i = 0; i < 4; i++) begin
            d.mem_wr[32+i] = pdb_pkg::pdb_odd_par(q.bus_s2.data[8*i +: 8]);
        end
        d.bus_rd = q.mem_s2[31:0];

        // Transceivers face the bus only for this board's own cycles
        d.board_sel_n = !sel_now;
        d.bus_oe_n = !(sel_now && q.bus_s2.read_not_write
                       && !q.bus_s2.buffer_drive_enable_n && !refresh_now);
        d.mem_oe_n = !(sel_now && !q.bus_s2.read_not_write
                       && !q.bus_s2.buffer_drive_enable_n && !refresh_now);

        // AXI4-Lite write address and data, taken in either order
        if (axi_req.awvalid && q.rsp.awready) begin
            d.aw_full = 1'b1;
            d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && q.rsp.wready) begin
            d.w_full = 1'b1;
            d.w_data = axi_req.wdata;
            d.w_strb = axi_req.wstrb;
        end
        if (q.rsp.bvalid && axi_req.bready) begin
            d.rsp.bvalid = 1'b0;
        end
        if (d.aw_full && d.w_full && !d.rsp.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full  = 1'b0;
            d.rsp.bvalid = 1'b1;
            d.rsp.bresp  = pdb_pkg::RESP_OKAY;
            unique case (d.aw_addr)
                pdb_pkg::REG_CTRL: begin
                    if (d.w_strb[0]) begin
                        d.ctrl_range = d.w_data[pdb_pkg::CTRL_RANGE_LSB +: 3];
                        d.ctrl_mode  = d.w_data[pdb_pkg::CTRL_MODE_LSB +: 3];
                    end
                end
                pdb_pkg::REG_STATUS: begin
                end
                pdb_pkg::REG_CLEAR: sw_clear = 1'b1;
                default: d.rsp.bresp = pdb_pkg::RESP_SLVERR;
            endcase
        end
        d.rsp.awready = !d.aw_full && !d.rsp.bvalid;
        d.rsp.wready  = !d.w_full && !d.rsp.bvalid;

        // AXI4-Lite read; reading the clear register also clears the flag
        if (q.rsp.rvalid && axi_req.rready) begin
            d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && q.rsp.arready) begin
            d.rsp.rvalid = 1'b1;
            d.rsp.rdata  = '0;
            d.rsp.rresp  = pdb_pkg::RESP_OKAY;
            unique case (axi_req.araddr)
                pdb_pkg::REG_CTRL: begin
                    d.rsp.rdata[pdb_pkg::CTRL_RANGE_LSB +: 3] = q.ctrl_range;
                    d.rsp.rdata[pdb_pkg::CTRL_MODE_LSB +: 3]  = q.ctrl_mode;
                end
                pdb_pkg::REG_STATUS: begin
                    d.rsp.rdata[pdb_pkg::STAT_FLAG_BIT] = q.flag;
                    d.rsp.rdata[pdb_pkg::STAT_LINE_BIT] = q.pf_s2;
                    d.rsp.rdata[pdb_pkg::STAT_RCNT_LSB +: pdb_pkg::RCNT_W] = q.rcnt;
                end
                pdb_pkg::REG_CLEAR: sw_clear = 1'b1;
                default: d.rsp.rresp = pdb_pkg::RESP_SLVERR;
            endcase
        end
        d.rsp.arready = !d.rsp.rvalid;

        // Flag: a capture in the same cycle as a clear still wins
        if (sw_clear || !q.bus_s2.parity_flag_clear_n) begin
            d.flag = 1'b0;
        end
        if (q.fsm == pdb_pkg::PDB_HOLD && stb_rise && q.acc_read && q.check_err) begin
            d.flag = 1'b1;
        end
        d.pf_oe_n = !d.flag;
    end

    // Single state register; bus and fault-line sync stages reset to their idle levels, memory data stages to zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.bus_s1  <= pdb_pkg::BUS_IDLE;
            q.bus_s2  <= pdb_pkg::BUS_IDLE;
            q.stb_prev <= 1'b1;
            q.pf_s1   <= 1'b1;
            q.pf_s2   <= 1'b1;
            q.mem_wr  <= '1; // Idle all-ones bytes already carry their parity
            q.fsm     <= pdb_pkg::PDB_IDLE;
            q.cas_n   <= 1'b1;
            q.acc_ble_n <= 4'hf;
            q.dram.bank_row_strobes_n <= 2'h3;
            q.dram.byte_column_strobes_n <= 4'hf;
            q.dram.dram_write_n <= 1'b1;
            q.board_sel_n <= 1'b1;
            q.bus_oe_n  <= 1'b1;
            q.mem_oe_n  <= 1'b1;
            q.pf_oe_n   <= 1'b1;
            q.ctrl_range <= pdb_pkg::CTRL_RANGE_RST;
            q.ctrl_mode  <= pdb_pkg::CTRL_MODE_RST;
            q.rsp.awready <= 1'b1;
            q.rsp.wready  <= 1'b1;
            q.rsp.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Every output but the constant-low parity_fault_out straight from the state register
    assign axi_rsp           = q.rsp;
    assign mem_wr_data       = q.mem_wr;
    assign bus_rd_data       = q.bus_rd;
    assign bus_drive_oe_n    = q.bus_oe_n;
    assign mem_drive_oe_n    = q.mem_oe_n;
    assign board_select_n    = q.board_sel_n;
    assign dram_out          = q.dram;
    assign parity_fault_out  = 1'b0;
    assign parity_fault_oe_n = q.pf_oe_n;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_select_decode: assert property (##1 board_select_n == !$past(sel_now))
        else $error("board select does not follow range decode");
    a_column_addr: assert property (q.fsm == pdb_pkg::PDB_HOLD
        |-> q.dram.dram_mux_addr == q.acc_addr[10:2])
        else $error("column address missing while column strobe active");
    a_row_before_col: assert property ($fell(q.cas_n)
        |-> q.dram.bank_row_strobes_n != 2'h3 && $past(q.fsm) == pdb_pkg::PDB_COL)
        else $error("column strobe without row strobe");
    a_bank_pick: assert property (q.fsm == pdb_pkg::PDB_HOLD
        |-> q.dram.bank_row_strobes_n == (q.acc_addr[20] ? 2'h1 : 2'h2))
        else $error("wrong bank row strobe");
    a_lane_gate: assert property (dram_out.byte_column_strobes_n
        == ({4{q.cas_n}} | q.acc_ble_n))
        else $error("lane column strobe not gated by enable");
    a_write_copy: assert property (##1 dram_out.dram_write_n
        == $past(q.bus_s2.read_not_write))
        else $error("write strobe not a copy of direction");
    a_no_unsel: assert property (q.fsm == pdb_pkg::PDB_IDLE && stb_fall
        && !refresh_now && !(sel_now && auto_mode) |=> q.fsm == pdb_pkg::PDB_IDLE)
        else $error("access started without select or auto mode");
    a_refresh_row: assert property (q.fsm == pdb_pkg::PDB_REFR
        |-> q.dram.dram_mux_addr == q.rcnt && q.cas_n)
        else $error("refresh row not from counter");
    a_parity_gen: assert property (##1 mem_wr_data[32]
        == pdb_pkg::pdb_odd_par($past(q.bus_s2.data[7:0])))
        else $error("lane 0 parity wrong");
    a_flag_capture: assert property (q.fsm == pdb_pkg::PDB_HOLD && stb_rise
        && q.acc_read && q.check_err |=> q.flag ##1 !parity_fault_oe_n)
        else $error("parity error not captured and driven");
    a_refresh_quiet: assert property (refresh_now
        |=> bus_drive_oe_n && mem_drive_oe_n)
        else $error("transceiver enabled in refresh");

    c_read: cover property (q.fsm == pdb_pkg::PDB_HOLD && q.acc_read && stb_rise);
    c_write: cover property (q.fsm == pdb_pkg::PDB_HOLD && !q.acc_read && stb_rise);
    c_refresh: cover property (q.fsm == pdb_pkg::PDB_REFR && stb_rise);
    c_fault: cover property ($rose(q.flag));

endmodule : pdb_board

/* File: verif/pdb_bus_master.sv */
`timescale 1ns/1ps
// Granted memory bus master: drives the board's bus pins one cycle at a time
module pdb_bus_master (
    input  wire logic            clk,
    output pdb_pkg::pdb_bus_in_t bus
);
    initial bus = pdb_pkg::BUS_IDLE;

    // Address phase one cycle ahead of the strobe for reads, two for writes to give write data its setup time
    task automatic begin_cycle(input logic [23:0] a, input logic rnw, input logic [3:0] be_n,
                               input logic [31:0] d, input logic refr_n);
        @(posedge clk);
        bus.address_valid_n       <= ~refr_n;
        bus.addr                  <= a;
        bus.byte_lane_enables_n   <= be_n;
        bus.read_not_write        <= rnw;
        bus.refresh_cycle_n       <= refr_n;
        bus.buffer_drive_enable_n <= ~refr_n;
        bus.data                  <= d;
        @(posedge clk);
        // Writes hold the strobe back a further cycle for data setup
        if (!rnw) @(posedge clk);
        bus.data_strobe_n <= 1'b0;
    endtask : begin_cycle

    // Strobe ends first; released lines then show the inverse of their last value
    task automatic end_cycle();
        @(posedge clk);
        bus.data_strobe_n         <= 1'b1;
        bus.buffer_drive_enable_n <= 1'b1;
        @(posedge clk);
        bus.address_valid_n <= 1'b1;
        bus.refresh_cycle_n <= 1'b1;
        bus.addr            <= ~bus.addr;
        bus.data            <= ~bus.data;
    endtask : end_cycle

    // Held low long enough to cross the board's synchronisers
    task automatic clear_pulse();
        @(posedge clk);
        bus.parity_flag_clear_n <= 1'b0;
        repeat (4) @(posedge clk);
        bus.parity_flag_clear_n <= 1'b1;
    endtask : clear_pulse
endmodule : pdb_bus_master

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam logic [23:0] A_RD = 24'h7a5b3c;
    localparam logic [23:0] A_WR = 24'h6c8a48;
    localparam logic [23:0] A_NO = 24'h2c8a48;
    localparam int          REFR_PERIOD_CYC = 640; // 16 us in 25 ns cycles
    logic                   clk = 1'b0;
    logic                   reset;
    pdb_pkg::pdb_axi_req_t  req;
    pdb_pkg::pdb_axi_rsp_t  rsp;
    pdb_pkg::pdb_bus_in_t   bus;
    pdb_pkg::pdb_dram_out_t dram;
    logic [35:0]            mem_rd;
    logic [35:0]            mem_wr;
    logic [31:0]            bus_rd;
    logic                   bus_oe_n;
    logic                   mem_oe_n;
    logic                   sel_n;
    logic                   fault_in;
    logic                   fault_out;
    logic                   fault_oe_n;
    int                     error_cnt = 0;
    int                     checked = 0;
    int                     cyc = 0;
    logic [31:0]            rd;
    logic [1:0]             resp;
    logic [8:0]             rc;

    always #12.5 clk = ~clk;
    // Open-drain fault line with its pull-up
    assign fault_in = fault_oe_n ? 1'b1 : fault_out;

    pdb_board i_dut (
        .clk(clk), .reset(reset), .axi_req(req), .axi_rsp(rsp), .bus_in(bus),
        .mem_rd_data(mem_rd), .mem_wr_data(mem_wr), .bus_rd_data(bus_rd),
        .bus_drive_oe_n(bus_oe_n), .mem_drive_oe_n(mem_oe_n), .board_select_n(sel_n),
        .dram_out(dram), .parity_fault_in(fault_in), .parity_fault_out(fault_out),
        .parity_fault_oe_n(fault_oe_n)
    );
    pdb_bus_master i_mst (.clk(clk), .bus(bus));

    task automatic end_sim();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // The whole run needs under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    // Odd parity per lane, parity bits above the data
    function automatic logic [35:0] with_par(input logic [31:0] d);
        return {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0], d};
    endfunction : with_par

    // Handshakes judged at the falling edge, so the rising edge that takes them is not raced
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, done;
        done = 1'b0;
        @(posedge clk);
        {req.awvalid, req.wvalid, req.bready} <= 3'h7;
        req.awaddr <= a;
        req.wdata  <= d;
        req.wstrb  <= 4'hf;
        while (!done) begin
            @(negedge clk);
            ta = req.awvalid & rsp.awready;
            tw = req.wvalid & rsp.wready;
            done = req.bready & rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (done) req.bready <= 1'b0;
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, done;
        done = 1'b0;
        @(posedge clk);
        {req.arvalid, req.rready} <= 2'h3;
        req.araddr <= a;
        while (!done) begin
            @(negedge clk);
            ta = req.arvalid & rsp.arready;
            done = req.rready & rsp.rvalid;
            d = rsp.rdata;
            r = rsp.rresp;
            @(posedge clk);
            if (ta) req.arvalid <= 1'b0;
            if (done) req.rready <= 1'b0;
        end
    endtask : axi_rd

    // One bus cycle, sampled at the fixed latencies of the row and column phases
    task automatic mem_cycle(input logic [23:0] a, input logic rnw, input logic [3:0] be_n,
        input logic [31:0] d, input logic refr_n, input logic [8:0] row, input logic [1:0] rs,
        input logic [3:0] cs, input logic sel, input logic [1:0] oe);
        i_mst.begin_cycle(a, rnw, be_n, d, refr_n);
        repeat (4) @(posedge clk);
        #1;
        chk(dram.bank_row_strobes_n, rs, "row strobes");
        chk(sel_n, sel, "board select");
        if (rs != 2'b11) chk(dram.dram_mux_addr, row, "row address");
        repeat (3) @(posedge clk);
        #1;
        chk(dram.byte_column_strobes_n, cs, "column strobes");
        chk({bus_oe_n, mem_oe_n}, oe, "transceiver enables");
        if (cs != 4'hf) chk(dram.dram_mux_addr, a[10:2], "column address");
        if (cs != 4'hf) chk(dram.dram_write_n, rnw, "write strobe");
        if (!rnw && cs != 4'hf) chk(mem_wr, with_par(d), "write parity");
        if (rnw && cs != 4'hf) chk(bus_rd, mem_rd[31:0], "read data");
        i_mst.end_cycle();
        repeat (3) @(posedge clk);
        #1;
        chk({dram.bank_row_strobes_n, dram.byte_column_strobes_n}, 6'h3f, "released");
    endtask : mem_cycle

    // Reset values, unmapped place, then the board's address range
    task automatic t_regs();
        axi_rd(pdb_pkg::REG_CTRL, rd, resp);
        chk({resp, rd}, {pdb_pkg::RESP_OKAY, 32'h0}, "ctrl reset");
        axi_rd(pdb_pkg::REG_STATUS, rd, resp);
        chk(rd[1:0], 2'b10, "flag after reset");
        axi_rd(8'h10, rd, resp);
        chk(resp, pdb_pkg::RESP_SLVERR, "unmapped read");
        axi_wr(8'h10, 32'h1, resp);
        chk(resp, pdb_pkg::RESP_SLVERR, "unmapped write");
        axi_wr(pdb_pkg::REG_CTRL, 32'h3, resp);
    endtask : t_regs

    // Reads in bank one, writes in bank zero, a foreign range and a manual mode
    task automatic t_access();
        mem_rd <= with_par(32'hc3a5_1e0f);
        mem_cycle(A_RD, 1'b1, 4'b1010, 32'h0, 1'b1,
                  A_RD[19:11], 2'b01, 4'b1010, 1'b0, 2'b01);
        chk(fault_oe_n, 1'b1, "good parity");
        mem_cycle(A_WR, 1'b0, 4'h0, 32'h5a0f_3c81, 1'b1,
                  A_WR[19:11], 2'b10, 4'h0, 1'b0, 2'b10);
        mem_cycle(A_NO, 1'b1, 4'h0, 32'h0, 1'b1, 9'h0, 2'b11, 4'hf, 1'b1, 2'b11);
        axi_wr(pdb_pkg::REG_CTRL, 32'h13, resp);
        mem_cycle(A_RD, 1'b1, 4'h0, 32'h0, 1'b1, 9'h0, 2'b11, 4'hf, 1'b0, 2'b01);
        axi_wr(pdb_pkg::REG_CTRL, 32'h3, resp);
    endtask : t_access

    // A bad lane parity raises the fault line until register or pin clears it
    task automatic t_parity();
        mem_rd <= with_par(32'h0f0f_00ff) ^ 36'h1_0000_0000;
        mem_cycle(A_RD, 1'b1, 4'h0, 32'h0, 1'b1, A_RD[19:11], 2'b01, 4'h0, 1'b0, 2'b01);
        chk({fault_oe_n, fault_in, fault_out}, 3'b000, "fault line");
        axi_rd(pdb_pkg::REG_STATUS, rd, resp);
        chk(rd[1:0], 2'b01, "status flag");
        axi_wr(pdb_pkg::REG_CLEAR, 32'h0, resp);
        repeat (2) @(posedge clk);
        #1;
        chk(fault_oe_n, 1'b1, "register clear");
        mem_cycle(A_RD, 1'b1, 4'h0, 32'h0, 1'b1, A_RD[19:11], 2'b01, 4'h0, 1'b0, 2'b01);
        chk(fault_oe_n, 1'b0, "flag set again");
        i_mst.clear_pulse();
        repeat (4) @(posedge clk);
        #1;
        chk(fault_oe_n, 1'b1, "pin clear");
    endtask : t_parity

    // Refresh at a foreign and at an own address: both banks, counter row, no data path, flag kept
    task automatic t_refresh();
        axi_rd(pdb_pkg::REG_STATUS, rd, resp);
        rc = rd[16:8];
        mem_rd <= with_par(32'h0) ^ 36'h2_0000_0000;
        mem_cycle(A_NO, 1'b1, 4'h0, 32'h0, 1'b0, rc, 2'b00, 4'hf, 1'b1, 2'b11);
        chk(fault_oe_n, 1'b1, "flag in refresh");
        // The central timer asks again one refresh period later
        repeat (REFR_PERIOD_CYC) @(posedge clk);
        mem_cycle(A_RD, 1'b1, 4'h0, 32'h0, 1'b0, rc + 9'h1, 2'b00, 4'hf, 1'b1, 2'b11);
        chk(fault_oe_n, 1'b1, "flag in own range refresh");
        axi_rd(pdb_pkg::REG_STATUS, rd, resp);
        chk(rd[16:8], rc + 9'h2, "refresh counter");
    endtask : t_refresh

    initial begin
        reset = 1'b1;
        req = '0;
        mem_rd = '0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        t_regs();
        t_access();
        t_parity();
        t_refresh();
        end_sim();
    end
endmodule : tb_top
